// ### hdl/fsqmc_pkg.sv
package fsqmc_pkg;

  // ----------------------------------------
  // Opcodes decoded by this block
  // ----------------------------------------
  localparam logic [7:0] OP_FR_READ = 8'h48;
  localparam logic [7:0] OP_FR_WRITE = 8'h42;
  localparam logic [7:0] OP_QUAD_ENTER = 8'h35;
  localparam logic [7:0] OP_QUAD_EXIT = 8'hF5;
  localparam logic [7:0] OP_SUSPEND_A = 8'h75;
  localparam logic [7:0] OP_SUSPEND_B = 8'hB0;
  localparam logic [7:0] OP_RESUME_A = 8'h7A;
  localparam logic [7:0] OP_RESUME_B = 8'h30;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;

  // ----------------------------------------
  // Opcodes allowed while suspended
  // ----------------------------------------
  localparam int N_READ = 18;
  localparam logic [N_READ-1:0][7:0] READ_OPS = {
    8'h03, 8'h13, 8'h0B, 8'h0C, 8'hBB, 8'hBC, 8'h3B, 8'h3C, 8'hEB,
    8'hEC, 8'h6B, 8'h6C, 8'h0D, 8'h0E, 8'hBD, 8'hBE, 8'hED, 8'hEE};
  localparam int N_COMMON = 31;
  localparam logic [N_COMMON-1:0][7:0] COMMON_OPS = {
    8'h06, 8'h04, 8'h05, 8'h48, 8'h16, 8'hC8, 8'h61, 8'h81, 8'hAB,
    8'h9F, 8'h90, 8'hAF, 8'h4B, 8'h5A, 8'h82, 8'h7A, 8'h30, 8'hC0,
    8'h63, 8'h83, 8'h17, 8'hC5, 8'hB7, 8'h29, 8'hFC, 8'hF2, 8'hFA,
    8'hE0, 8'hE7, 8'hA7, 8'h2B};
  localparam int N_ERASE_SUSPENDED_FLAG = 12;
  localparam logic [N_ERASE_SUSPENDED_FLAG-1:0][7:0] ERASE_SUSPENDED_FLAG_OPS = {
    8'h24, 8'h26, 8'h25, 8'h75, 8'hB0, 8'h02, 8'h12, 8'h32, 8'h38,
    8'h34, 8'h3E, 8'hFB};

  // ----------------------------------------
  // Function register layout
  // ----------------------------------------
  localparam int FR_RST_DIS = 0;
  localparam int FR_PROGRAM_SUSPENDED_FLAG = 2;
  localparam int FR_ERASE_SUSPENDED_FLAG = 3;
  localparam int FR_IRL_LSB = 4;
  localparam logic [7:0] FR_OTP_MASK = 8'hF1;
  localparam logic [7:0] FR_RESET = 8'h00;

  // ----------------------------------------
  // Frame bit counts and pin masks
  // ----------------------------------------
  localparam int ADDR_W = 24;
  localparam logic [5:0] OPC_END = 6'h08;
  localparam logic [5:0] DAT_END = 6'h10;
  localparam logic [5:0] ADR_END = 6'h20;
  localparam logic [5:0] STEP_QUAD = 6'h04;
  localparam logic [5:0] STEP_SER = 6'h01;
  localparam logic [1:0] NB_OPC = 2'h1;
  localparam logic [1:0] NB_DAT = 2'h2;
  localparam logic [3:0] IO_SO = 4'h2;
  localparam logic [3:0] IO_ALL = 4'hF;
  localparam logic [3:0] IO_NONE = 4'h0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int TSUS_US = 100;
  localparam int CLK_MHZ = 200;
  localparam int SUSPEND_CYC = TSUS_US * CLK_MHZ;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    FSQMC_KIND_NONE,
    FSQMC_KIND_PROGRAM,
    FSQMC_KIND_ERASE,
    FSQMC_KIND_CHIP
  } fsqmc_kind_t;

  typedef struct packed {
    logic busy;
    fsqmc_kind_t kind;
    logic done;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] mask;
  } fsqmc_eng_t;

  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [7:0] data;
  } fsqmc_cmd_t;

endpackage

// ### hdl/fsqmc_top.sv
// How it works
// - Function register read shifts register contents out
// - Reset-disable bit set stops reset pin
// - Write sets each info row lock bit
// - One-time bits never return to zero
// - Quad enter makes all transfers four-bit
// - Quad exit is one two-clock quad cycle
// - Suspend and resume codes in both modes
// - Suspend flags are function bits two, three
// - Suspend latency before ready, about 100 us
// - Suspend ignored during whole chip erase
// - Erase suspend blocks writes, erases, region reads
// - Program suspend blocks writes, programs, page reads
// - Suspend acts only after chip select rises
// - Erase suspend sets flag, then waits ready
// - Program suspend sets flag, then waits ready
// - Any suspend clears the write enable latch
// - Resume restarts operation, clears its flag
// - Quad cycle is two nibbles, MSB first
// - Reads, status, ids accepted in any suspend
// - Volatile sets, resume, protect reads accepted
// - Erase suspend adds program, lock, suspend
// - Busy flag high while operation executes
`timescale 1ns/1ps

module fsqmc_top #(
  parameter int SUSPEND_CYCLES = fsqmc_pkg::SUSPEND_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  input fsqmc_pkg::fsqmc_eng_t eng,
  output logic [1:0] eng_pause,
  output fsqmc_pkg::fsqmc_cmd_t cmd_fwd,
  output logic cmd_refused,
  output logic write_enable_latch,
  output logic write_in_progress_flag,
  output logic quad_mode,
  output logic reset_pin_honoured,
  output logic [3:0] info_row_lock_bits,
  output logic read_refused
);

  // ----------------------------------------
  // Shared state
  // ----------------------------------------
  localparam int LW = $clog2(SUSPEND_CYCLES + 1);

  logic [7:0] fr_q; // Function register, clk domain
  logic quad_q; // Quad mode, clk domain
  logic [LW-1:0] lat_q; // Suspend latency countdown

  // Link side reads fr_q, quad_q and eng fields as quasi-static words:
  // the clk side changes them only after a frame has ended, so they are
  // settled long before the next frame's first edge. Limitation: CS must
  // stay high for at least four clk cycles between frames.
  logic program_suspended_flag;
  logic erase_suspended_flag;
  assign program_suspended_flag = fr_q[fsqmc_pkg::FR_PROGRAM_SUSPENDED_FLAG];
  assign erase_suspended_flag = fr_q[fsqmc_pkg::FR_ERASE_SUSPENDED_FLAG];

  // ----------------------------------------
  // Link: frame counter and input shifter
  // ----------------------------------------
  logic [5:0] cnt_q; // Bits received this frame
  logic [5:0] cnt_d;
  logic [31:0] sh_q; // Incoming bit shifter
  logic [31:0] sh_d;
  logic op_hit; // Opcode completes on this edge
  logic dat_hit; // First data byte completes
  logic adr_hit; // Address completes

  // Next shift value, one bit or one nibble per edge
  always_comb begin
    if (quad_q) begin
      sh_d = {sh_q[27:0], io_in};
      cnt_d = cnt_q + fsqmc_pkg::STEP_QUAD;
    end else begin
      sh_d = {sh_q[30:0], io_in[0]};
      cnt_d = cnt_q + fsqmc_pkg::STEP_SER;
    end
    // Saturate so long data phases do not wrap
    if (cnt_q >= fsqmc_pkg::ADR_END) begin
      cnt_d = cnt_q;
    end
    op_hit = (cnt_q < fsqmc_pkg::OPC_END) && (cnt_d == fsqmc_pkg::OPC_END);
    dat_hit = (cnt_q < fsqmc_pkg::DAT_END) && (cnt_d == fsqmc_pkg::DAT_END);
    adr_hit = (cnt_q < fsqmc_pkg::ADR_END) && (cnt_d == fsqmc_pkg::ADR_END);
  end

  // Counter and shifter are cleared by the frame itself, since sck may
  // stand still between frames
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      cnt_q <= 6'h00;
      sh_q <= 32'h0000_0000;
    end else begin
      cnt_q <= cnt_d;
      sh_q <= sh_d;
    end
  end

  // ----------------------------------------
  // Link: captured command, kept past the frame
  // ----------------------------------------
  logic [7:0] op_q; // Last opcode
  logic [7:0] dat_q; // First byte after opcode
  logic [1:0] nb_q; // Bytes seen in last frame
  logic tgl_q; // Flips once per opcode

  // Capture registers survive CS high so the clk side can act on them
  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      op_q <= 8'h00;
      dat_q <= 8'h00;
      nb_q <= 2'h0;
      tgl_q <= 1'b0;
    end else begin
      if (op_hit) begin
        op_q <= sh_d[7:0];
        nb_q <= fsqmc_pkg::NB_OPC;
        tgl_q <= ~tgl_q;
      end
      if (dat_hit) begin
        dat_q <= sh_d[7:0];
        nb_q <= fsqmc_pkg::NB_DAT;
      end
    end
  end

  // ----------------------------------------
  // Opcode classes
  // ----------------------------------------
  logic hit_rd; // Array read opcode
  logic hit_cm; // Allowed in any suspend
  logic hit_es; // Allowed in erase suspend only

  // Table lookups on the captured opcode
  always_comb begin
    hit_rd = 1'b0;
    hit_cm = 1'b0;
    hit_es = 1'b0;
    for (int i = 0; i < fsqmc_pkg::N_READ; i++) begin
      if (fsqmc_pkg::READ_OPS[i] == op_q) begin
        hit_rd = 1'b1;
      end
    end
    for (int i = 0; i < fsqmc_pkg::N_COMMON; i++) begin
      if (fsqmc_pkg::COMMON_OPS[i] == op_q) begin
        hit_cm = 1'b1;
      end
    end
    for (int i = 0; i < fsqmc_pkg::N_ERASE_SUSPENDED_FLAG; i++) begin
      if (fsqmc_pkg::ERASE_SUSPENDED_FLAG_OPS[i] == op_q) begin
        hit_es = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Link: read guard for the suspended region
  // ----------------------------------------
  logic rd_ref_q;
  logic [fsqmc_pkg::ADDR_W-1:0] rd_addr;
  assign rd_addr = sh_d[fsqmc_pkg::ADDR_W-1:0];

  // Decided once the address is in; held to the end of the frame
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      rd_ref_q <= 1'b0;
    end else if (adr_hit && hit_rd && (program_suspended_flag || erase_suspended_flag)) begin
      rd_ref_q <= ((rd_addr & eng.mask) == (eng.addr & eng.mask));
    end
  end
  assign read_refused = rd_ref_q;

  // ----------------------------------------
  // Link: function register read-out
  // ----------------------------------------
  logic [7:0] out_q; // Output shifter, current bits at the top
  logic [2:0] left_q; // Shifts left in this byte
  logic oe_q; // Driving the data lines
  logic rd_go;
  assign rd_go = (op_q == fsqmc_pkg::OP_FR_READ) && (cnt_q >= fsqmc_pkg::OPC_END);

  // Launch on the falling edge so the host samples on the rising one;
  // the byte repeats for as long as the host keeps clocking
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      out_q <= 8'h00;
      left_q <= 3'h0;
      oe_q <= 1'b0;
    end else if (rd_go) begin
      oe_q <= 1'b1;
      if (!oe_q || (left_q == 3'h0)) begin
        out_q <= fr_q;
        left_q <= quad_q ? 3'h1 : 3'h7;
      end else begin
        out_q <= quad_q ? {out_q[3:0], 4'h0} : {out_q[6:0], 1'b0};
        left_q <= left_q - 3'h1;
      end
    end
  end

  // Serial mode drives SO only; quad drives all four lines
  assign io_out = quad_q ? out_q[7:4] : {2'b00, out_q[7], 1'b0};
  assign io_oe = !oe_q ? fsqmc_pkg::IO_NONE : (quad_q ? fsqmc_pkg::IO_ALL : fsqmc_pkg::IO_SO);

  // ----------------------------------------
  // Crossing: frame end and command toggle
  // ----------------------------------------
  logic [2:0] cs_sy_q; // CS synchroniser, [0] first
  logic [2:0] tg_sy_q; // Toggle synchroniser, [0] first
  logic cs_lvl_q; // Accepted CS level
  logic seen_q; // Toggle value already served
  logic cs_rise;
  logic new_cmd;

  // Three stages; only stage two and three are looked at
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cs_sy_q <= 3'b111;
      tg_sy_q <= 3'b000;
    end else begin
      cs_sy_q <= {cs_sy_q[1:0], cs_n};
      tg_sy_q <= {tg_sy_q[1:0], tgl_q};
    end
  end

  // A change counts once stage two and three agree
  assign cs_rise = (cs_sy_q[1] == cs_sy_q[2]) && cs_sy_q[2] && !cs_lvl_q;
  assign new_cmd = cs_rise && (tg_sy_q[1] == tg_sy_q[2]) && (tg_sy_q[2] != seen_q);

  // Track accepted CS level and served toggle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cs_lvl_q <= 1'b1;
      seen_q <= 1'b0;
    end else begin
      if (cs_sy_q[1] == cs_sy_q[2]) begin
        cs_lvl_q <= cs_sy_q[2];
      end
      if (new_cmd) begin
        seen_q <= tg_sy_q[2];
      end
    end
  end

  // ----------------------------------------
  // Command filter and decode
  // ----------------------------------------
  logic allowed;
  logic poll;
  logic accept;
  logic is_sus;
  logic is_res;
  logic sus_prog;
  logic sus_erase;
  logic res_prog;
  logic res_erase;
  logic do_write_enable_cmd;
  logic do_write_disable_cmd;
  logic do_function_reg_write_cmd;
  logic local_op;

  // Op codes are read only at frame end, when sck has stopped
  always_comb begin
    allowed = !(program_suspended_flag || erase_suspended_flag) || hit_rd || hit_cm;
    if (erase_suspended_flag && !program_suspended_flag && hit_es) begin
      allowed = 1'b1;
    end
    // Status and function reads stay open so the host can poll
    poll = (op_q == fsqmc_pkg::OP_STATUS_READ) || (op_q == fsqmc_pkg::OP_FR_READ);
    accept = new_cmd && allowed && ((lat_q == '0) || poll);
    is_sus = (op_q == fsqmc_pkg::OP_SUSPEND_A) || (op_q == fsqmc_pkg::OP_SUSPEND_B);
    is_res = (op_q == fsqmc_pkg::OP_RESUME_A) || (op_q == fsqmc_pkg::OP_RESUME_B);
    // Chip erase is not suspendable and leaves flags alone
    sus_prog = accept && is_sus && eng.busy && !program_suspended_flag
      && (eng.kind == fsqmc_pkg::FSQMC_KIND_PROGRAM);
    sus_erase = accept && is_sus && eng.busy && !erase_suspended_flag
      && (eng.kind == fsqmc_pkg::FSQMC_KIND_ERASE);
    // Nested program resumes first; nothing suspended means no effect
    res_prog = accept && is_res && program_suspended_flag;
    res_erase = accept && is_res && erase_suspended_flag && !program_suspended_flag;
    do_write_enable_cmd = accept && (op_q == fsqmc_pkg::OP_WRITE_ENABLE);
    do_write_disable_cmd = accept && (op_q == fsqmc_pkg::OP_WRITE_DISABLE);
    do_function_reg_write_cmd = accept && (op_q == fsqmc_pkg::OP_FR_WRITE) && write_enable_latch
      && (nb_q == fsqmc_pkg::NB_DAT);
    local_op = is_sus || is_res || (op_q == fsqmc_pkg::OP_FR_WRITE)
      || (op_q == fsqmc_pkg::OP_QUAD_ENTER) || (op_q == fsqmc_pkg::OP_QUAD_EXIT);
  end

  // ----------------------------------------
  // Function register
  // ----------------------------------------
  // One-time bits only ever gain ones; suspend flags follow commands
  always_ff @(posedge clk) begin
    if (!rstn) begin
      fr_q <= fsqmc_pkg::FR_RESET;
    end else begin
      if (do_function_reg_write_cmd) begin
        fr_q <= fr_q | (dat_q & fsqmc_pkg::FR_OTP_MASK);
      end
      if (sus_prog) begin
        fr_q[fsqmc_pkg::FR_PROGRAM_SUSPENDED_FLAG] <= 1'b1;
      end else if (res_prog) begin
        fr_q[fsqmc_pkg::FR_PROGRAM_SUSPENDED_FLAG] <= 1'b0;
      end
      if (sus_erase) begin
        fr_q[fsqmc_pkg::FR_ERASE_SUSPENDED_FLAG] <= 1'b1;
      end else if (res_erase) begin
        fr_q[fsqmc_pkg::FR_ERASE_SUSPENDED_FLAG] <= 1'b0;
      end
    end
  end

  assign reset_pin_honoured = !fr_q[fsqmc_pkg::FR_RST_DIS];
  assign info_row_lock_bits = fr_q[fsqmc_pkg::FR_IRL_LSB +: 4];
  assign eng_pause = {erase_suspended_flag, program_suspended_flag};

  // ----------------------------------------
  // Write enable latch
  // ----------------------------------------
  // A set in the same cycle as a completion clear wins
  always_ff @(posedge clk) begin
    if (!rstn) begin
      write_enable_latch <= 1'b0;
    end else if (do_write_enable_cmd) begin
      write_enable_latch <= 1'b1;
    end else if (do_write_disable_cmd || do_function_reg_write_cmd || sus_prog || sus_erase || eng.done) begin
      write_enable_latch <= 1'b0;
    end
  end

  // ----------------------------------------
  // Quad mode
  // ----------------------------------------
  // Enter only from serial; exit only as a quad cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      quad_q <= 1'b0;
    end else if (accept && !quad_q && (op_q == fsqmc_pkg::OP_QUAD_ENTER)) begin
      quad_q <= 1'b1;
    end else if (accept && quad_q && (op_q == fsqmc_pkg::OP_QUAD_EXIT)) begin
      quad_q <= 1'b0;
    end
  end
  assign quad_mode = quad_q;

  // ----------------------------------------
  // Suspend latency and busy flag
  // ----------------------------------------
  // Commands other than polls wait out this count after a suspend
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lat_q <= '0;
    end else if (sus_prog || sus_erase) begin
      lat_q <= LW'(SUSPEND_CYCLES);
    end else if (lat_q != '0) begin
      lat_q <= lat_q - LW'(1);
    end
  end

  // Engine drops busy while paused, so busy here means executing or counting suspend latency
  always_ff @(posedge clk) begin
    if (!rstn) begin
      write_in_progress_flag <= 1'b0;
    end else begin
      write_in_progress_flag <= eng.busy || (lat_q != '0);
    end
  end

  // ----------------------------------------
  // Forwarded and refused commands
  // ----------------------------------------
  // One-cycle pulses toward the rest of the device
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cmd_fwd <= '0;
      cmd_refused <= 1'b0;
    end else begin
      cmd_fwd.valid <= accept && !local_op;
      cmd_fwd.opcode <= op_q;
      cmd_fwd.data <= dat_q;
      cmd_refused <= new_cmd && !accept;
    end
  end

endmodule // fsqmc_top

// ### bench/fsqmc_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker for the suspend and quad logic
// ----------------------------------------
module fsqmc_monitor #(
  parameter int SUSPEND_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic [3:0] io_oe,
  input fsqmc_pkg::fsqmc_eng_t eng,
  input wire logic [1:0] eng_pause,
  input fsqmc_pkg::fsqmc_cmd_t cmd_fwd,
  input wire logic cmd_refused,
  input wire logic write_enable_latch,
  input wire logic write_in_progress_flag,
  input wire logic quad_mode,
  input wire logic reset_pin_honoured,
  input wire logic [3:0] info_row_lock_bits
);
  // All checks live in the system clock domain
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  otp_locks_a: assert property ((($past(info_row_lock_bits) & ~info_row_lock_bits) == 4'h0))
    else $error("lock bit went back to zero");
  rst_pin_a: assert property (!$rose(reset_pin_honoured))
    else $error("reset pin honoured again");
  wel_clear_a: assert property ($rose(|eng_pause) |-> ##[0:1] !write_enable_latch)
    else $error("write enable survived suspend");
  sus_busy_a: assert property ($rose(|eng_pause) |=> write_in_progress_flag [*8])
    else $error("busy flag low in suspend latency");
  sus_after_cs_a: assert property ($rose(|eng_pause) |-> cs_n && $past(cs_n, 3))
    else $error("suspend acted inside frame");
  erase_kind_a: assert property ($rose(eng_pause[1]) |->
    $past(eng.kind) == fsqmc_pkg::FSQMC_KIND_ERASE)
    else $error("erase pause without erase");
  prog_kind_a: assert property ($rose(eng_pause[0]) |->
    $past(eng.kind) == fsqmc_pkg::FSQMC_KIND_PROGRAM)
    else $error("program pause without program");
  no_sr_write_a: assert property (cmd_fwd.valid && (|eng_pause) |-> cmd_fwd.opcode != 8'h01)
    else $error("status write passed in suspend");
  no_prog_a: assert property (cmd_fwd.valid && eng_pause == 2'b01 |->
    !(cmd_fwd.opcode inside {8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3E}))
    else $error("program passed in program suspend");
  refuse_pulse_a: assert property (cmd_refused |-> !cmd_fwd.valid ##1 !cmd_refused)
    else $error("refusal pulse malformed");
  oe_width_a: assert property (!cs_n && io_oe != 4'h0 |->
    io_oe == (quad_mode ? 4'hF : 4'h2))
    else $error("output lanes do not match mode");
  oe_idle_a: assert property (cs_n |-> io_oe == 4'h0)
    else $error("driving while deselected");
  busy_flag_a: assert property (eng.busy |=> write_in_progress_flag)
    else $error("busy flag low while executing");
endmodule // fsqmc_monitor

// ### bench/fsqmc_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host controller model on the serial link
// ----------------------------------------
module fsqmc_host (
  output logic sck,
  output logic cs_n,
  output logic [3:0] io_in,
  input wire logic [3:0] io_out
);
  // Clock parked low, device deselected; the select rises a little after
  // time zero so the link side sees a real edge and clears itself
  initial begin
    sck = 1'b0;
    io_in = 4'h5;
    #1 cs_n = 1'b1;
  end

  // One framed transfer: nb bits out (right aligned), nrd bits back
  task automatic frame(input logic [31:0] tx, input int nb, input bit quad, input int nrd,
                       output logic [7:0] rx);
    int st;
    int i;
    st = quad ? 4 : 1;
    rx = 8'h00;
    #3 cs_n = 1'b0;
    for (i = nb; i > 0; i -= st) begin
      // Data moves after the falling edge, MSB or high nibble first
      io_in = quad ? tx[i-1 -: 4] : {~io_in[3:1], tx[i-1]};
      #40 sck = 1'b1;
      #40 sck = 1'b0;
    end
    for (i = 0; i < nrd; i += st) begin
      // Unused inputs toggle so nothing stale looks valid
      io_in = ~io_in;
      #40 sck = 1'b1;
      rx = quad ? {rx[3:0], io_out} : {rx[6:0], io_out[1]};
      #40 sck = 1'b0;
    end
    #20 cs_n = 1'b1;
    io_in = ~io_in;
    // Deselect gap well above four system clocks
    #30;
  endtask
endmodule // fsqmc_host

// ### bench/test_flash_suspend_quad_mode_control.sv
`timescale 1ns/1ps
module test_flash_suspend_quad_mode_control;
  // ----------------------------------------
  // Signals and reference state
  // ----------------------------------------
  localparam int SUS = 400; // Long enough to land a frame inside the latency
  logic clk = 1'b0;
  logic rstn; // Unknown until a real falling edge clears the link capture
  logic sck, cs_n;
  logic [3:0] io_in, io_out, io_oe, info_row_lock_bits;
  fsqmc_pkg::fsqmc_eng_t eng = '0;
  logic [1:0] eng_pause;
  fsqmc_pkg::fsqmc_cmd_t cmd_fwd;
  logic cmd_refused, write_enable_latch, write_in_progress_flag, quad_mode;
  logic reset_pin_honoured, read_refused;
  logic [7:0] rx, d;
  int miscompares = 0;
  int checks = 0;
  int seed = 32'h240b_b9b3;
  int fr_m = 0; // Reference function register
  int quad_m = 0; // Reference link mode
  int nref = 0;
  int fwd_op = 0;
  int rref = 0;
  int k;

  always #2.5 clk = ~clk;

  fsqmc_top #(.SUSPEND_CYCLES(SUS)) uut (
    .clk(clk),
    .rstn(rstn),
    .sck(sck),
    .cs_n(cs_n),
    .io_in(io_in),
    .io_out(io_out),
    .io_oe(io_oe),
    .eng(eng),
    .eng_pause(eng_pause),
    .cmd_fwd(cmd_fwd),
    .cmd_refused(cmd_refused),
    .write_enable_latch(write_enable_latch),
    .write_in_progress_flag(write_in_progress_flag),
    .quad_mode(quad_mode),
    .reset_pin_honoured(reset_pin_honoured),
    .info_row_lock_bits(info_row_lock_bits),
    .read_refused(read_refused)
  );
  fsqmc_host host (
    .sck(sck),
    .cs_n(cs_n),
    .io_in(io_in),
    .io_out(io_out)
  );

  // Sticky capture of short pulses between frames
  always @(posedge clk) begin
    if (cmd_refused === 1'b1) nref++;
    if (cmd_fwd.valid === 1'b1) fwd_op = cmd_fwd.opcode;
    if (read_refused === 1'b1) rref = 1;
  end

  // ----------------------------------------
  // Compare, stimulus and closing tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t byte got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t flag got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Frame in the current mode, then let the clk side act on it
  task automatic cmd(input logic [7:0] o, input logic [23:0] a, input int nb, input int nrd);
    nref = 0;
    fwd_op = 0;
    rref = 0;
    host.frame({o, a} >> (32 - nb), nb, quad_m != 0, nrd, rx);
    repeat (10) @(posedge clk);
  endtask

  // Engine state, changed just after an edge
  task automatic set_eng(input logic busy, input fsqmc_pkg::fsqmc_kind_t kd);
    @(posedge clk);
    #1;
    eng.busy = busy;
    eng.kind = kd;
    eng.addr = 24'h01_2300;
    eng.mask = 24'hFF_FF00;
  endtask

  // Poll the busy flag under a bound instead of a fixed wait
  task automatic wait_wip();
    int n;
    for (n = 0; n < 1000 && write_in_progress_flag !== 1'b0; n++) @(posedge clk);
    if (n == 1000) begin
      miscompares++;
      $display("[FAIL] %0t busy flag stuck", $time);
      summarize();
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    // Falling edge off the clock edge, so the asynchronous link clear fires
    #1 rstn = 1'b0;
    repeat (2) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (6) @(posedge clk);
    chk({4'h0, info_row_lock_bits}, 8'h00);
    chkb(reset_pin_honoured, 1'b1);
    chkb(write_in_progress_flag, 1'b0);
    $display("test reset done");

    // Random one-time bits, every other pass tries to clear them
    for (k = 0; k < 4; k++) begin
      d = (k % 2) ? 8'h00 : 8'($random(seed));
      cmd(8'h06, 24'h00_0000, 8, 0);
      chkb(write_enable_latch, 1'b1);
      cmd(8'h42, {d, 16'h0000}, 16, 0);
      fr_m = fr_m | int'(d & fsqmc_pkg::FR_OTP_MASK);
      cmd(8'h48, 24'h00_0000, 8, 8);
      chk(rx, 8'(fr_m));
      chk({4'h0, info_row_lock_bits}, 8'(fr_m >> 4));
      chkb(reset_pin_honoured, fr_m[0] == 0);
    end
    $display("test function register done");

    // Program suspend, latency, filter, region reads, resume
    cmd(8'h06, 24'h00_0000, 8, 0);
    set_eng(1'b1, fsqmc_pkg::FSQMC_KIND_PROGRAM);
    repeat (4) @(posedge clk);
    chkb(write_in_progress_flag, 1'b1);
    cmd(8'h75, 24'h00_0000, 8, 0);
    chkb(eng_pause[0], 1'b1);
    chkb(write_enable_latch, 1'b0);
    set_eng(1'b0, fsqmc_pkg::FSQMC_KIND_PROGRAM);
    cmd(8'h06, 24'h00_0000, 8, 0);
    chkb(nref == 1, 1'b1);
    chkb(write_in_progress_flag, 1'b1);
    wait_wip();
    cmd(8'h48, 24'h00_0000, 8, 8);
    chk(rx, 8'(fr_m | 4));
    cmd(8'h02, 24'h00_0000, 8, 0);
    chkb(nref == 1, 1'b1);
    cmd(8'h01, 24'h00_0000, 8, 0);
    chkb(nref == 1, 1'b1);
    cmd(8'h03, 24'h01_2345, 32, 0);
    chkb(rref == 1, 1'b1);
    cmd(8'h03, 24'h05_0000, 32, 0);
    chkb(rref == 0, 1'b1);
    cmd(8'h7A, 24'h00_0000, 8, 0);
    chkb(eng_pause[0], 1'b0);
    set_eng(1'b0, fsqmc_pkg::FSQMC_KIND_NONE);
    $display("test program suspend done");

    // Erase suspend in quad mode
    cmd(8'h35, 24'h00_0000, 8, 0);
    quad_m = 1;
    chkb(quad_mode, 1'b1);
    repeat (SUS) @(posedge clk);
    set_eng(1'b1, fsqmc_pkg::FSQMC_KIND_ERASE);
    cmd(8'hB0, 24'h00_0000, 8, 0);
    chkb(eng_pause[1], 1'b1);
    set_eng(1'b0, fsqmc_pkg::FSQMC_KIND_ERASE);
    wait_wip();
    cmd(8'h48, 24'h00_0000, 8, 8);
    chk(rx, 8'(fr_m | 8));
    cmd(8'h02, 24'h00_0000, 8, 0);
    chk(8'(fwd_op), 8'h02);
    cmd(8'h20, 24'h00_0000, 8, 0);
    chkb(nref == 1, 1'b1);
    cmd(8'h30, 24'h00_0000, 8, 0);
    chkb(eng_pause[1], 1'b0);
    cmd(8'hF5, 24'h00_0000, 8, 0);
    quad_m = 0;
    chkb(quad_mode, 1'b0);
    $display("test erase suspend done");

    // Chip erase cannot be suspended; lone resume is harmless
    set_eng(1'b1, fsqmc_pkg::FSQMC_KIND_CHIP);
    cmd(8'h75, 24'h00_0000, 8, 0);
    chk({6'h00, eng_pause}, 8'h00);
    set_eng(1'b0, fsqmc_pkg::FSQMC_KIND_NONE);
    wait_wip();
    cmd(8'h7A, 24'h00_0000, 8, 0);
    cmd(8'h48, 24'h00_0000, 8, 8);
    chk(rx, 8'(fr_m));
    $display("test chip erase and idle resume done");
    summarize();
  end
endmodule // test_flash_suspend_quad_mode_control

bind fsqmc_top fsqmc_monitor #(.SUSPEND_CYCLES(SUSPEND_CYCLES)) mon (
  .clk(clk),
  .rstn(rstn),
  .cs_n(cs_n),
  .io_oe(io_oe),
  .eng(eng),
  .eng_pause(eng_pause),
  .cmd_fwd(cmd_fwd),
  .cmd_refused(cmd_refused),
  .write_enable_latch(write_enable_latch),
  .write_in_progress_flag(write_in_progress_flag),
  .quad_mode(quad_mode),
  .reset_pin_honoured(reset_pin_honoured),
  .info_row_lock_bits(info_row_lock_bits)
);
